// file: core/interval_timer_readback.sv
// How it works
// - Ports 40h-42h pick counters; reads follow LSB, MSB or LSB-then-MSB format.
// - Counters zero and one always count; unlatched reads may catch a change.
// - Counter two counts only while its gate input is high; stopped reads stable.
// - Latch command freezes a counter's hold latch until read or reprogrammed.
// - Latching never stops counting nor changes the programmed mode.
// - A second latch before the read is ignored; first value is returned.
// - Two-byte reads may be split by any delay or other counter accesses.
// - Each counter keeps its own read and write byte pointers.
// - Read-back latches count and/or status of selected counters for port reads.
// - Read-back count bit low latches counts; each unlatches on its own read.
// - Repeated count read-backs before the read are ignored.
// - Read-back status bit low latches status, readable only once latched.
// - Repeated status latches before the read are ignored.
// - Both bits low latch count and status, each with first-latch-wins.
// - With both latched, status reads first, then the count bytes, then live.
// - Writes to 43h go to the write-only control word register.
`timescale 1ns/100ps
`default_nettype none

module interval_timer_readback #(
	parameter int TICK_DIV = interval_timer_readback_pkg::TICK_DIV_DEFAULT
) (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [7:0] io_addr,
	input  wire logic       io_rd,
	input  wire logic       io_wr,
	input  wire logic [7:0] io_wdata,
	input  wire logic       spkr_gate_en,
	output logic      [7:0] io_rdata,
	output logic            io_rvalid,
	output logic      [2:0] timer_out
);

	typedef struct packed {
		logic [15:0] ce;         // counting element
		logic [15:0] cr;         // count register
		logic [15:0] count_hold_latch;
		logic [7:0]  st;         // latched status
		logic        hold_full;
		logic        st_full;
		logic        rd_msb;     // read pointer
		logic        wr_msb;     // write pointer
		logic        load_pend;
		logic        null_cnt;
		logic        out;
		logic [1:0]  rw;
		logic [2:0]  mode;
		logic        bcd;
	} ctr_t;

	typedef struct packed {
		ctr_t [2:0]  ctr;
		logic [15:0] pre;
		logic [7:0]  rdata;
		logic        rvalid;
	} state_t;

	state_t s_reg;
	state_t s_next;

	logic       cw_wr;
	logic       tick;
	logic [2:0] gate;
	logic [2:0] rd_hit;
	logic [2:0] wr_hit;
	logic [2:0] lat_cnt;
	logic [2:0] lat_st;
	logic [2:0] prog;

	// Divider length that the prescaler register can hold
	if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_div
		$error("TICK_DIV out of range");
	end

	// Status byte of one counter
	function automatic logic [7:0] status_of(input ctr_t c);
		status_of = {c.out, c.null_cnt, c.rw, c.mode, c.bcd};
	endfunction : status_of

	// Port index decode
	function automatic logic port_is(input logic [7:0] a, input int i);
		port_is = a == interval_timer_readback_pkg::PORT_CTR0 + 8'(i);
	endfunction : port_is

	// Request decode per counter
	assign cw_wr = io_wr && io_addr == interval_timer_readback_pkg::PORT_CTRL;
	assign gate  = {spkr_gate_en, 1'b1, 1'b1};
	assign tick  = s_reg.pre == 16'h0000;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			rd_hit[i] = io_rd && port_is(io_addr, i);
			wr_hit[i] = io_wr && port_is(io_addr, i);
			prog[i]   = 1'b0;
			lat_cnt[i] = 1'b0;
			lat_st[i]  = 1'b0;
			if (cw_wr) begin
				if (io_wdata[7:6] == interval_timer_readback_pkg::SC_READBACK) begin
					// Read-back select bits, counter i at bit 1+i
					lat_cnt[i] = io_wdata[interval_timer_readback_pkg::RB_SEL_LSB + i]
						&& !io_wdata[interval_timer_readback_pkg::RB_COUNT_N_BIT];
					lat_st[i] = io_wdata[interval_timer_readback_pkg::RB_SEL_LSB + i]
						&& !io_wdata[interval_timer_readback_pkg::RB_STATUS_N_BIT];
				end else if (io_wdata[7:6] == 2'(i)) begin
					lat_cnt[i] = io_wdata[5:4] == interval_timer_readback_pkg::RW_LATCH;
					prog[i] = io_wdata[5:4] != interval_timer_readback_pkg::RW_LATCH;
				end
			end
		end
	end

	// Next state: prescaler, counting, latching, port reads and writes
	always_comb begin
		logic [15:0] val;
		logic        done;
		val = 16'h0000;
		done = 1'b0;
		s_next = s_reg;
		s_next.rvalid = 1'b0;
		s_next.pre = tick ? 16'(TICK_DIV - 1) : s_reg.pre - 16'h0001;
		if (io_rd) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = interval_timer_readback_pkg::READ_IDLE;
		end
		for (int i = 0; i < 3; i++) begin
			// Counting element, independent of any latch
			if (tick && s_reg.ctr[i].load_pend) begin
				s_next.ctr[i].ce = s_reg.ctr[i].cr;
				s_next.ctr[i].load_pend = 1'b0;
				s_next.ctr[i].null_cnt = 1'b0;
				s_next.ctr[i].out = 1'b0;
			end else if (tick && gate[i]) begin
				s_next.ctr[i].ce = s_reg.ctr[i].ce - 16'h0001;
				if (s_reg.ctr[i].ce == 16'h0001) begin
					s_next.ctr[i].out = 1'b1;
				end
			end
			// Latches capture only when empty: first one wins
			if (lat_cnt[i] && !s_reg.ctr[i].hold_full) begin
				s_next.ctr[i].count_hold_latch = s_reg.ctr[i].ce;
				s_next.ctr[i].hold_full = 1'b1;
			end
			if (lat_st[i] && !s_reg.ctr[i].st_full) begin
				s_next.ctr[i].st = status_of(s_reg.ctr[i]);
				s_next.ctr[i].st_full = 1'b1;
			end
			// Reprogramming drops latches and resets both pointers
			if (prog[i]) begin
				s_next.ctr[i].rw = io_wdata[5:4];
				s_next.ctr[i].mode = io_wdata[3:1];
				s_next.ctr[i].bcd = io_wdata[0];
				s_next.ctr[i].hold_full = 1'b0;
				s_next.ctr[i].st_full = 1'b0;
				s_next.ctr[i].rd_msb = 1'b0;
				s_next.ctr[i].wr_msb = 1'b0;
				s_next.ctr[i].null_cnt = 1'b1;
				s_next.ctr[i].out = 1'b0;
			end
			// Port read: status first, then count bytes
			if (rd_hit[i]) begin
				if (s_reg.ctr[i].st_full) begin
					s_next.rdata = s_reg.ctr[i].st;
					s_next.ctr[i].st_full = 1'b0;
				end else begin
					val = s_reg.ctr[i].hold_full ?
						s_reg.ctr[i].count_hold_latch : s_reg.ctr[i].ce;
					case (s_reg.ctr[i].rw)
						interval_timer_readback_pkg::RW_MSB: begin
							s_next.rdata = val[15:8];
							done = 1'b1;
						end
						interval_timer_readback_pkg::RW_LH: begin
							s_next.rdata = s_reg.ctr[i].rd_msb ? val[15:8] : val[7:0];
							s_next.ctr[i].rd_msb = !s_reg.ctr[i].rd_msb;
							done = s_reg.ctr[i].rd_msb;
						end
						default: begin
							s_next.rdata = val[7:0];
							done = 1'b1;
						end
					endcase
					if (done) begin
						s_next.ctr[i].hold_full = 1'b0;
					end
				end
			end
			// Port write: own write pointer, load on the next tick
			if (wr_hit[i]) begin
				case (s_reg.ctr[i].rw)
					interval_timer_readback_pkg::RW_MSB: begin
						s_next.ctr[i].cr = {io_wdata, 8'h00};
						s_next.ctr[i].load_pend = 1'b1;
						s_next.ctr[i].null_cnt = 1'b1;
					end
					interval_timer_readback_pkg::RW_LH: begin
						if (s_reg.ctr[i].wr_msb) begin
							s_next.ctr[i].cr[15:8] = io_wdata;
							s_next.ctr[i].load_pend = 1'b1;
							s_next.ctr[i].null_cnt = 1'b1;
						end else begin
							s_next.ctr[i].cr[7:0] = io_wdata;
						end
						s_next.ctr[i].wr_msb = !s_reg.ctr[i].wr_msb;
					end
					default: begin
						s_next.ctr[i].cr = {8'h00, io_wdata};
						s_next.ctr[i].load_pend = 1'b1;
						s_next.ctr[i].null_cnt = 1'b1;
					end
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= {$bits(state_t){interval_timer_readback_pkg::RESET_BIT}};
		end else begin
			s_reg <= s_next;
		end
	end

	assign io_rdata  = s_reg.rdata;
	assign io_rvalid = s_reg.rvalid;
	assign timer_out = {s_reg.ctr[2].out, s_reg.ctr[1].out, s_reg.ctr[0].out};

	// Per-counter checks
	for (genvar g = 0; g < 3; g++) begin : g_chk
		property p_latch_capture;
			@(posedge ref_clk) disable iff (!rst_n)
			lat_cnt[g] && !s_reg.ctr[g].hold_full && !rd_hit[g]
			|=> s_reg.ctr[g].hold_full
			&& s_reg.ctr[g].count_hold_latch == $past(s_reg.ctr[g].ce);
		endproperty
		a_latch_capture: assert property (p_latch_capture)
			else $error("count not captured by latch");

		property p_first_latch_wins;
			@(posedge ref_clk) disable iff (!rst_n)
			s_reg.ctr[g].hold_full && lat_cnt[g] && !rd_hit[g] && !prog[g]
			|=> $stable(s_reg.ctr[g].count_hold_latch);
		endproperty
		a_first_latch_wins: assert property (p_first_latch_wins)
			else $error("second count latch overwrote the first");

		property p_latch_keeps_mode;
			@(posedge ref_clk) disable iff (!rst_n)
			lat_cnt[g] && !prog[g]
			|=> $stable(s_reg.ctr[g].mode) && $stable(s_reg.ctr[g].rw);
		endproperty
		a_latch_keeps_mode: assert property (p_latch_keeps_mode)
			else $error("latch changed programmed mode");

		property p_status_first;
			@(posedge ref_clk) disable iff (!rst_n)
			rd_hit[g] && s_reg.ctr[g].st_full
			|=> io_rvalid && io_rdata == $past(s_reg.ctr[g].st)
			&& !s_reg.ctr[g].st_full;
		endproperty
		a_status_first: assert property (p_status_first)
			else $error("latched status not returned first");

		property p_status_hold;
			@(posedge ref_clk) disable iff (!rst_n)
			s_reg.ctr[g].st_full && lat_st[g] && !rd_hit[g] && !prog[g]
			|=> $stable(s_reg.ctr[g].st) && s_reg.ctr[g].st_full;
		endproperty
		a_status_hold: assert property (p_status_hold)
			else $error("repeated status latch not ignored");

		property p_status_capture;
			@(posedge ref_clk) disable iff (!rst_n)
			lat_st[g] && !s_reg.ctr[g].st_full
			|=> s_reg.ctr[g].st == status_of($past(s_reg.ctr[g]));
		endproperty
		a_status_capture: assert property (p_status_capture)
			else $error("status not captured");

		property p_lsb_read;
			@(posedge ref_clk) disable iff (!rst_n)
			rd_hit[g] && !s_reg.ctr[g].st_full && !s_reg.ctr[g].hold_full
			&& s_reg.ctr[g].rw == interval_timer_readback_pkg::RW_LSB
			|=> io_rdata == $past(s_reg.ctr[g].ce[7:0]);
		endproperty
		a_lsb_read: assert property (p_lsb_read)
			else $error("low byte read returned wrong value");

		property p_two_byte_unlatch;
			@(posedge ref_clk) disable iff (!rst_n)
			rd_hit[g] && !s_reg.ctr[g].st_full && s_reg.ctr[g].hold_full
			&& s_reg.ctr[g].rw == interval_timer_readback_pkg::RW_LH
			|=> s_reg.ctr[g].hold_full == !$past(s_reg.ctr[g].rd_msb);
		endproperty
		a_two_byte_unlatch: assert property (p_two_byte_unlatch)
			else $error("latch released at the wrong byte");

		property p_latched_pair;
			@(posedge ref_clk) disable iff (!rst_n)
			rd_hit[g] && !s_reg.ctr[g].st_full && s_reg.ctr[g].hold_full
			&& s_reg.ctr[g].rw == interval_timer_readback_pkg::RW_LH
			|=> io_rdata == ($past(s_reg.ctr[g].rd_msb) ?
			$past(s_reg.ctr[g].count_hold_latch[15:8]) :
			$past(s_reg.ctr[g].count_hold_latch[7:0]));
		endproperty
		a_latched_pair: assert property (p_latched_pair)
			else $error("latched byte returned out of order");

		property p_count_step;
			@(posedge ref_clk) disable iff (!rst_n)
			tick && gate[g] && !s_reg.ctr[g].load_pend
			|=> s_reg.ctr[g].ce == $past(s_reg.ctr[g].ce) - 16'h0001;
		endproperty
		a_count_step: assert property (p_count_step)
			else $error("counting element skipped a tick");
	end

	property p_gate_stops;
		@(posedge ref_clk) disable iff (!rst_n)
		!spkr_gate_en && !s_reg.ctr[2].load_pend
		|=> $stable(s_reg.ctr[2].ce);
	endproperty
	a_gate_stops: assert property (p_gate_stops)
		else $error("counter two moved with gate off");

	// Every read gets its answer strobe one cycle later
	property p_read_answer;
		@(posedge ref_clk) disable iff (!rst_n)
		io_rd |=> io_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read got no answer strobe");

	property p_ctrl_read_idle;
		@(posedge ref_clk) disable iff (!rst_n)
		io_rd && io_addr == interval_timer_readback_pkg::PORT_CTRL
		|=> io_rdata == interval_timer_readback_pkg::READ_IDLE;
	endproperty
	a_ctrl_read_idle: assert property (p_ctrl_read_idle)
		else $error("control port read not idle");

	// Counter one has no gate of its own and never stalls
	property p_free_run;
		@(posedge ref_clk) disable iff (!rst_n)
		tick && !s_reg.ctr[1].load_pend
		|=> s_reg.ctr[1].ce != $past(s_reg.ctr[1].ce);
	endproperty
	a_free_run: assert property (p_free_run)
		else $error("counter one stood still");

endmodule : interval_timer_readback

`default_nettype wire

// file: core/interval_timer_readback_pkg.sv
`default_nettype none

package interval_timer_readback_pkg;

	// Port map, low address byte
	localparam logic [7:0] PORT_CTR0 = 8'h40;
	localparam logic [7:0] PORT_CTR1 = 8'h41;
	localparam logic [7:0] PORT_CTR2 = 8'h42;
	localparam logic [7:0] PORT_CTRL = 8'h43;

	// Control word fields
	localparam int CW_SC_LSB   = 6;
	localparam int CW_RW_LSB   = 4;
	localparam int CW_MODE_LSB = 1;
	localparam int CW_BCD_BIT  = 0;

	// Select and access codes
	localparam logic [1:0] SC_READBACK = 2'h3;
	localparam logic [1:0] RW_LATCH    = 2'h0;
	localparam logic [1:0] RW_LSB      = 2'h1;
	localparam logic [1:0] RW_MSB      = 2'h2;
	localparam logic [1:0] RW_LH       = 2'h3;

	// Read-back command fields, latch bits active low
	localparam int RB_COUNT_N_BIT  = 5;
	localparam int RB_STATUS_N_BIT = 4;
	localparam int RB_SEL_LSB      = 1;

	// Status byte layout
	localparam int ST_OUT_BIT  = 7;
	localparam int ST_NULL_BIT = 6;

	// Read answer for the write-only or unmapped ports
	localparam logic [7:0] READ_IDLE = 8'hFF;

	// Timer clock derived from the reference clock
	localparam int REF_CLK_HZ       = 20000000;
	localparam int TIMER_CLK_HZ     = 1193000;
	localparam int TICK_DIV_DEFAULT = REF_CLK_HZ / TIMER_CLK_HZ;

	// Value after reset of every state bit
	localparam logic RESET_BIT = 1'b0;

endpackage : interval_timer_readback_pkg

`default_nettype wire

// file: test/io_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// Host side of the I/O port, one access at a time
module io_host_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] io_rdata,
	input  wire logic       io_rvalid,
	output logic      [7:0] io_addr,
	output logic            io_rd,
	output logic            io_wr,
	output logic      [7:0] io_wdata
);
	// Idle bus at time zero
	initial begin
		io_addr  = 8'h00;
		io_rd    = 1'b0;
		io_wr    = 1'b0;
		io_wdata = 8'h00;
	end

	// One-cycle write strobe; lines inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#5;
		io_addr  = a;
		io_wdata = d;
		io_wr    = 1'b1;
		@(posedge ref_clk);
		#5;
		io_wr    = 1'b0;
		io_addr  = ~a;
		io_wdata = ~d;
	endtask : wr

	// One-cycle read strobe; answer taken after the taking edge lands
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge ref_clk);
		#5;
		io_addr = a;
		io_rd   = 1'b1;
		@(posedge ref_clk);
		#5;
		d       = io_rdata;
		v       = io_rvalid;
		io_rd   = 1'b0; // Sole reader, byte pairs may be split by other accesses
		io_addr = ~a;
	endtask : rd
endmodule : io_host_model

`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	localparam logic [7:0] CW_LH = {2'h2, interval_timer_readback_pkg::RW_LH,
		4'h0};
	localparam logic [7:0] LATCH2 = {2'h2,
		interval_timer_readback_pkg::RW_LATCH, 4'h0};
	localparam logic [7:0] RB_BOTH2 = {
		interval_timer_readback_pkg::SC_READBACK, 6'b001000};
	localparam logic [7:0] ST_EXP = {2'b00,
		interval_timer_readback_pkg::RW_LH, 4'h0};
	localparam logic [7:0] P2 = interval_timer_readback_pkg::PORT_CTR2;
	localparam logic [7:0] PC = interval_timer_readback_pkg::PORT_CTRL;
	localparam logic [7:0] P1 = interval_timer_readback_pkg::PORT_CTR1;
	localparam logic [7:0] CW_LSB1 = {2'h1,
		interval_timer_readback_pkg::RW_LSB, 4'h0};
	localparam logic [7:0] CW_LSB2 = {2'h2,
		interval_timer_readback_pkg::RW_LSB, 4'h0};
	localparam logic [7:0] RB_ST12 = {
		interval_timer_readback_pkg::SC_READBACK, 6'b101100};
	localparam logic [7:0] ST_OUT = {1'b1, 1'b0,
		interval_timer_readback_pkg::RW_LSB, 4'h0};

	logic       ref_clk;
	logic       rst_n;
	logic       spkr_gate_en;
	logic [7:0] io_addr;
	logic       io_rd;
	logic       io_wr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       io_rvalid;
	logic [2:0] timer_out;
	int         errors;
	int         num_checks;

	// Clock generator
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	interval_timer_readback #(.TICK_DIV(2)) dut (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.io_addr      (io_addr),
		.io_rd        (io_rd),
		.io_wr        (io_wr),
		.io_wdata     (io_wdata),
		.spkr_gate_en (spkr_gate_en),
		.io_rdata     (io_rdata),
		.io_rvalid    (io_rvalid),
		.timer_out    (timer_out)
	);

	io_host_model host (
		.ref_clk   (ref_clk),
		.io_rdata  (io_rdata),
		.io_rvalid (io_rvalid),
		.io_addr   (io_addr),
		.io_rd     (io_rd),
		.io_wr     (io_wr),
		.io_wdata  (io_wdata)
	);

	// Compare and count
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Read one byte and compare, answer strobe included
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		host.rd(a, d, v);
		chk("rvalid", {7'h00, v}, 8'h01);
		chk("rdata", d, e);
	endtask : rd_chk

	// Counter two in two-byte format, count 1234h, gate stopped
	task automatic prog2();
		spkr_gate_en = 1'b0;
		host.wr(PC, CW_LH);
		host.wr(P2, 8'h34);
		host.wr(P2, 8'h12);
		repeat (4) @(posedge ref_clk);
	endtask : prog2

	// Let counter two run a few timer ticks
	task automatic run2();
		@(posedge ref_clk);
		#5;
		spkr_gate_en = 1'b1;
		repeat (10) @(posedge ref_clk);
		#5;
		spkr_gate_en = 1'b0;
	endtask : run2

	task automatic t_direct();
		prog2();
		rd_chk(P2, 8'h34);
		rd_chk(P2, 8'h12);
		rd_chk(PC, interval_timer_readback_pkg::READ_IDLE);
	endtask : t_direct

	task automatic t_latch();
		logic [7:0] d;
		logic       v;
		prog2();
		host.wr(PC, LATCH2);
		run2();
		host.wr(PC, LATCH2);
		rd_chk(P2, 8'h34);
		host.wr(P1, 8'h05);
		rd_chk(PC, interval_timer_readback_pkg::READ_IDLE);
		rd_chk(P2, 8'h12);
		host.rd(P2, d, v);
		chk("live_lsb", d, 8'h2F);
		rd_chk(P2, 8'h12);
		host.wr(PC, RB_BOTH2);
		rd_chk(P2, ST_EXP);
		rd_chk(P2, 8'h2F);
		rd_chk(P2, 8'h12);
	endtask : t_latch

	task automatic t_readback();
		prog2();
		host.wr(PC, RB_BOTH2);
		run2();
		host.wr(PC, RB_BOTH2);
		rd_chk(P2, ST_EXP);
		rd_chk(P2, 8'h34);
		rd_chk(P2, 8'h12);
	endtask : t_readback

	task automatic t_interleave();
		prog2();
		rd_chk(P2, 8'h34);
		host.wr(P2, 8'h78);
		rd_chk(P2, 8'h12);
		host.wr(P2, 8'h56);
		repeat (4) @(posedge ref_clk);
		rd_chk(P2, 8'h78);
		rd_chk(P2, 8'h56);
	endtask : t_interleave

	// Counter outputs, status-only read-back over two counters
	task automatic t_out();
		host.wr(PC, CW_LSB1);
		host.wr(P1, 8'h02);
		host.wr(PC, CW_LSB2);
		host.wr(P2, 8'h03);
		repeat (4) @(posedge ref_clk);
		#5;
		chk("out_loaded", {5'h00, timer_out}, 8'h02);
		run2();
		chk("out_expired", {5'h00, timer_out}, 8'h06);
		host.wr(PC, RB_ST12);
		rd_chk(P2, ST_OUT);
		rd_chk(P2, 8'hFE);
		rd_chk(P1, ST_OUT);
	endtask : t_out

	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	// Main sequence
	initial begin
		errors       = 0;
		num_checks   = 0;
		rst_n        = 1'b0;
		spkr_gate_en = 1'b0;
		repeat (3) @(posedge ref_clk);
		#5;
		rst_n = 1'b1;
		t_direct();
		t_latch();
		t_readback();
		t_interleave();
		t_out();
		conclude();
	end

	// Watchdog against a hang
	initial begin
		#200us;
		errors++;
		conclude();
	end
endmodule : tb_top

`default_nettype wire
